//--- dv/asr_host_model.sv
// Host model that clocks results out of the converter control
`timescale 1ns/10ps
module asr_host_model (
  input  wire logic        i_start,
  input  wire logic [4:0]  i_edges,
  input  wire logic        i_hold,
  input  wire logic [7:0]  i_lag,
  input  wire logic        i_line,
  output logic             o_sclk,
  output logic [23:0]      o_word,
  output logic             o_busy
);
  initial begin
    o_sclk = 1'b0;
    o_word = 24'h000000;
    o_busy = 1'b0;
  end
  // ==========================================================================
  // One frame: a lag, then a 64 ns shift clock; it stands low between frames unless i_hold keeps it high
  always @(posedge i_start) begin
    o_busy = 1'b1;
    o_word = 24'h000000;
    #(32 + i_lag);
    for (int k = 0; k < i_edges; k++) begin
      o_sclk = 1'b1;
      #32;
      if (k < 24) o_word = {o_word[22:0], i_line};
      o_sclk = 1'b0;
      #32;
    end
    o_sclk = i_hold;
    o_busy = 1'b0;
    // Lifting the hold ends standby; one process owns the clock
    wait (!i_hold);
    o_sclk = 1'b0;
  end
endmodule

//--- dv/asr_readout_ctrl_chk.sv
// Port-level checks of the converter readout control
`timescale 1ns/10ps
module asr_readout_ctrl_chk #(
  parameter int UPDATE_CYC_P = 20
) (
  input wire logic        i_mclk,
  input wire logic        i_srst,
  input wire logic        i_power_down_n,
  input wire logic        i_sclk,
  input wire logic        i_rate_fast,
  input wire logic        i_xtal_sel,
  input wire logic        i_raw_valid,
  input wire logic [23:0] i_raw_data,
  input wire logic        o_raw_ready,
  input wire logic        o_data_ready_out,
  input wire logic        o_analog_en,
  input wire logic        o_osc_en,
  input wire logic        o_short_inputs,
  input wire logic        o_standby,
  input wire logic        o_calibrating
);
  localparam int UPD_HI = UPDATE_CYC_P + 4;
  logic [15:0] hi_cnt_r;
  // ==========================================================================
  // Length of the current high run on the line, saturating
  always_ff @(posedge i_mclk) begin
    if (i_srst || !o_data_ready_out) hi_cnt_r <= 16'h0000;
    else if (hi_cnt_r != 16'hffff) hi_cnt_r <= hi_cnt_r + 16'h0001;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // ==========================================================================
  // Assertions
  AST_RESET_STATE: assert property (disable iff (1'b0) i_srst |=>
    o_data_ready_out && !o_osc_en && !o_calibrating && !o_standby)
    else $error("reset state wrong");
  AST_OFF_STATE: assert property (!o_osc_en && !$past(o_osc_en) |->
    o_data_ready_out && !o_analog_en && !o_standby && !o_calibrating)
    else $error("power-down state not quiet");
  AST_PDN_SHUTS: assert property (!i_power_down_n [*3] |=> !o_osc_en)
    else $error("power-down pin ignored");
  AST_STBY_ANALOG_OFF: assert property (o_standby |-> !o_analog_en && o_osc_en)
    else $error("standby power wrong");
  AST_STBY_ENTRY: assert property ($rose(o_standby) |-> i_sclk)
    else $error("standby without held shift clock");
  AST_STBY_HOLD: assert property (o_standby && i_sclk && $past(i_sclk) &&
    $past(i_sclk, 2) && i_power_down_n && $past(i_power_down_n, 2) |=> o_standby)
    else $error("standby left while clock high");
  AST_STBY_EXIT: assert property ((o_standby && !i_sclk) [*3] |=> !o_standby)
    else $error("standby not left");
  AST_CAL_START: assert property ($rose(o_calibrating) |-> i_sclk)
    else $error("calibration without shift edge");
  AST_CAL_DONE: assert property ($fell(o_calibrating) && o_analog_en |->
    ##[1:UPD_HI] $fell(o_data_ready_out))
    else $error("no ready after calibration");
  AST_UPDATE_GAP: assert property ($fell(o_data_ready_out) && !i_sclk |->
    hi_cnt_r >= UPDATE_CYC_P)
    else $error("update interval too short");
  // Main scenarios reached
  COV_STBY: cover property ($rose(o_standby));
  COV_CAL: cover property ($rose(o_calibrating));
  COV_FULL: cover property (!o_raw_ready);
  COV_PDN: cover property ($fell(o_osc_en));
endmodule

bind asr_readout_ctrl asr_readout_ctrl_chk #(.UPDATE_CYC_P(UPDATE_CYC_P)) i_chk (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_power_down_n(i_power_down_n),
  .i_sclk(i_sclk), .i_rate_fast(i_rate_fast), .i_xtal_sel(i_xtal_sel),
  .i_raw_valid(i_raw_valid), .i_raw_data(i_raw_data), .o_raw_ready(o_raw_ready),
  .o_data_ready_out(o_data_ready_out), .o_analog_en(o_analog_en),
  .o_osc_en(o_osc_en), .o_short_inputs(o_short_inputs),
  .o_standby(o_standby), .o_calibrating(o_calibrating));

//--- dv/asr_readout_ctrl_tb.sv
// Self-checking bench for the converter readout control
`timescale 1ns/10ps
module asr_readout_ctrl_tb;
  import asr_pkg::*;
  localparam int SLOW = 1200;
  localparam int FAST = 600;
  localparam int UPD  = 20;
  localparam int XTAL = 50;
  logic             mclk = 1'b0;
  logic             srst = 1'b1;
  logic             pdn = 1'b1;
  logic             rate = 1'b1;
  logic             xtal = 1'b0;
  logic             raw_valid = 1'b0;
  logic             src_en = 1'b1;
  logic             h_start = 1'b0;
  logic             h_hold = 1'b0;
  logic             cal_pend = 1'b0;
  logic [4:0]       h_edges = 5'h00;
  logic [7:0]       h_lag = 8'h00;
  logic [RES_W-1:0] raw_data = 24'h000000;
  logic [RES_W-1:0] last_pop = 24'h000000;
  logic [RES_W-1:0] off = 24'h000000;
  logic [RES_W-1:0] exp_w = 24'h000000;
  logic [RES_W-1:0] h_word;
  logic [RES_W-1:0] q[$];
  logic             sclk, h_busy, line, raw_ready, analog_en, osc_en, standby, cal;
  logic             short_in;
  logic [31:0]      seed = 32'h35a92af6;
  int               failures = 0;
  int               checked = 0;
  int               cyc = 0;
  int               hi, tot, n;
  int               tbl[6] = '{24, 25, 20, 26, 24, 30};

  always #2 mclk = ~mclk;

  asr_readout_ctrl #(.CONV_SLOW_P(SLOW), .CONV_FAST_P(FAST), .UPDATE_CYC_P(UPD),
    .XTAL_CYC_P(XTAL), .BUF_DEPTH(2)) i_dut (
    .i_mclk(mclk), .i_srst(srst), .i_power_down_n(pdn), .i_sclk(sclk),
    .i_rate_fast(rate), .i_xtal_sel(xtal), .i_raw_valid(raw_valid),
    .i_raw_data(raw_data), .o_raw_ready(raw_ready), .o_data_ready_out(line),
    .o_analog_en(analog_en), .o_osc_en(osc_en), .o_short_inputs(short_in),
    .o_standby(standby), .o_calibrating(cal));

  asr_host_model i_host (.i_start(h_start), .i_edges(h_edges), .i_hold(h_hold),
    .i_lag(h_lag), .i_line(line), .o_sclk(sclk), .o_word(h_word), .o_busy(h_busy));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Full-scale codes mixed in so that offset removal clips now and then
  function automatic logic [RES_W-1:0] next_word();
    logic [31:0] r;
    r = rnd();
    if (r[31:30] == 2'b00) return r[0] ? CODE_POS_FS : CODE_NEG_FS;
    return r[RES_W-1:0];
  endfunction
  function automatic logic [RES_W-1:0] exp_word(input logic [RES_W-1:0] raw,
                                                input logic [RES_W-1:0] ofs);
    logic [RES_W:0] d;
    d = {raw[RES_W-1], raw} - {ofs[RES_W-1], ofs};
    if (d[RES_W] != d[RES_W-1]) return d[RES_W] ? CODE_NEG_FS : CODE_POS_FS;
    return d[RES_W-1:0];
  endfunction
  task automatic check(input logic [RES_W-1:0] got, input logic [RES_W-1:0] want);
    checked++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, want);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Word source; mirrors the two-entry buffer so the popped word is known.
  // Flushing states empty it; the mirror is cleared in standby and power-down, not during the crystal wait.
  always @(posedge mclk) begin
    if (srst || standby || !osc_en) q.delete();
    else if (raw_valid && raw_ready) begin
      if (q.size() == 2) last_pop = q.pop_front();
      q.push_back(raw_data);
      raw_data <= next_word();
    end
    raw_valid <= src_en;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      test_done();
    end
  end

  // ==========================================================================
  // Sequences
  task automatic next_result();
    hi = 0;
    tot = 0;
    while (line !== 1'b1) @(posedge mclk) tot++;
    while (line === 1'b1) @(posedge mclk) begin
      hi++;
      tot++;
    end
    if (cal_pend) begin
      off = last_pop;
      cal_pend = 1'b0;
      exp_w = OFFSET_RESET;
    end
    else exp_w = exp_word(last_pop, off);
  endtask
  task automatic frame(input int e, input logic hold);
    @(posedge mclk);
    h_edges <= 5'(e);
    h_hold <= hold;
    h_lag <= 8'(rnd());
    h_start <= 1'b1;
    @(posedge mclk);
    h_start <= 1'b0;
    while (h_busy) @(posedge mclk);
    if (e >= 24) check(h_word, exp_w);
    if (e >= 26) cal_pend = 1'b1;
  endtask
  task automatic rd(input int e);
    frame(e, 1'b0);
    if (e == 24) check({23'h0, line}, {23'h0, exp_w[0]});
    if (e >= 25) check({23'h0, line}, 24'h000001);
    next_result();
    if (e == 24) check({23'h0, hi >= UPD}, 24'h000001);
    if (e >= 25) check({23'h0, hi > UPD + 8}, 24'h000001);
  endtask
  // Standby, calibrating on return when the frame gave extra edges
  task automatic stby(input int e);
    src_en <= 1'b0;
    frame(e, 1'b1);
    while (standby !== 1'b1) @(posedge mclk);
    check({22'h0, analog_en, osc_en}, 24'h000001);
    repeat (40) @(posedge mclk);
    check({23'h0, standby}, 24'h000001);
    h_hold <= 1'b0;
    while (standby === 1'b1) @(posedge mclk);
    check({22'h0, cal, short_in}, {22'h0, cal_pend, cal_pend});
    src_en <= 1'b1;
    next_result();
    rd(24);
  endtask
  task automatic pwr(input logic x);
    src_en <= 1'b0;
    pdn <= 1'b0;
    repeat (8) @(posedge mclk);
    check({22'h0, osc_en, line}, 24'h000001);
    xtal <= x;
    pdn <= 1'b1;
    n = 0;
    while (analog_en !== 1'b1) @(posedge mclk) n++;
    if (x) check({23'h0, n >= XTAL}, 24'h000001);
    else check({23'h0, n < 8}, 24'h000001);
    src_en <= 1'b1;
    off = OFFSET_RESET;
    cal_pend = 1'b0;
    next_result();
    rd(24);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    next_result();
    next_result();
    check(24'(tot), 24'(FAST));
    rate <= 1'b0;
    next_result();
    next_result();
    check(24'(tot), 24'(SLOW));
    rate <= 1'b1;
    next_result();
    for (int i = 0; i < 10; i++) rd(i < 6 ? tbl[i] : tbl[rnd() % 6]);
    stby(0);
    stby(26);
    pwr(1'b1);
    pwr(1'b0);
    test_done();
  end
endmodule

//--- logic/asr_fifo.sv
// Small valid/ready buffer for raw conversion words
`timescale 1ns/10ps
module asr_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  // ==========================================================================
  // Parameter check
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("asr_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  // Handshakes; full and empty come straight from the fill count
  assign o_wr_ready = (count_r != CW'(DEPTH));
  assign o_rd_valid = (count_r != '0);
  assign o_rd_data  = mem_r[rd_ptr_r];
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = o_rd_valid && i_rd_ready;

  // Storage has no reset; only valid entries are ever read
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_wr_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // Fill count
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      count_r <= '0;
    end else begin
      case ({push, pop})
        2'b10:   count_r <= count_r + 1'b1;
        2'b01:   count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end

endmodule

//--- logic/asr_pkg.sv
// Shared constants and types for the serial readout control of the converter
package asr_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned RES_W = 24;              // Conversion word width
  localparam int unsigned CNT_W = 23;              // Timer width, covers all counts
  localparam int unsigned EDG_W = 5;               // Shift clock edge counter width

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;       // Core clock period
  localparam int unsigned T_UPDATE_NS   = 39000;   // Output register update, least
  localparam int unsigned T_XTAL_NS     = 20000000; // Crystal start-up, about 20 ms
  // Least times round up to whole cycles
  localparam int unsigned UPDATE_CYC = (T_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned XTAL_CYC   = (T_XTAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CLKS_SLOW = 491520; // Clocks per result, slow rate
  localparam int unsigned CONV_CLKS_FAST = 61440;  // Clocks per result, fast rate

  // ==========================================================================
  // Shift clock edge counts after a ready indication
  localparam logic [EDG_W-1:0] EDGE_RESET = 5'h00;
  localparam logic [EDG_W-1:0] EDGE_LAST  = 5'h18; // Bits 1..24 shifted out
  localparam logic [EDG_W-1:0] EDGE_HIGH  = 5'h18; // Count before the 25th edge
  localparam logic [EDG_W-1:0] EDGE_CAL   = 5'h19; // Count before the 26th edge
  localparam logic [EDG_W-1:0] EDGE_STOP  = 5'h1a; // Saturation, later edges ignored

  // ==========================================================================
  // Reset values and codes
  localparam logic [RES_W-1:0] OFFSET_RESET = 24'h000000;
  localparam logic [RES_W-1:0] CODE_POS_FS  = 24'h7fffff;
  localparam logic [RES_W-1:0] CODE_NEG_FS  = 24'h800000;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 23'h000000;
  localparam logic             LINE_IDLE    = 1'b1;

  // ==========================================================================
  // Control states
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_WAKE    = 3'b001,
    ST_CONV    = 3'b010,
    ST_UPDATE  = 3'b011,
    ST_STANDBY = 3'b100
  } asr_state_t;

endpackage

//--- logic/asr_readout_ctrl.sv
// Conversion sequencing and serial readout control of the converter
`timescale 1ns/10ps

// Summary of operation
// - After power-up and reset, convert continuously without any host command.
// - Drive the data/ready line low when a conversion result is ready.
// - Each shift clock rising edge after ready puts out one bit, MSB first.
// - Hold LSB after 24 edges; next result raises then lowers the line.
// - An unread or partly read result is overwritten by the newer one.
// - A 25th edge forces the line high until the next result.
// - A 26th edge after a read starts offset calibration at once.
// - Calibration converts shorted inputs, stores offset, subtracts it later.
// - Line goes low when offset calibration has finished.
// - Standby powers down everything except the crystal amplifier.
// - Shift clock low leaves standby; first new result pulls line low.
// - Standby entered after extra edges calibrates on return before results.
// - Power-down low shuts down all circuitry including the oscillator.
// - External clock resumes at once; crystal waits about 20 ms.
// - A result takes 491,520 clocks slow or 61,440 clocks fast.
// - Results are 24-bit two's complement, clipped to full scale codes.
module asr_readout_ctrl
  import asr_pkg::*;
#(
  parameter int unsigned CONV_SLOW_P  = CONV_CLKS_SLOW,
  parameter int unsigned CONV_FAST_P  = CONV_CLKS_FAST,
  parameter int unsigned UPDATE_CYC_P = UPDATE_CYC,
  parameter int unsigned XTAL_CYC_P   = XTAL_CYC,
  parameter int unsigned BUF_DEPTH    = 2
) (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic             i_power_down_n,
  input  wire logic             i_sclk,
  input  wire logic             i_rate_fast,
  input  wire logic             i_xtal_sel,
  input  wire logic             i_raw_valid,
  input  wire logic [RES_W-1:0] i_raw_data,
  output logic                  o_raw_ready,
  output logic                  o_data_ready_out,
  output logic                  o_analog_en,
  output logic                  o_osc_en,
  output logic                  o_short_inputs,
  output logic                  o_standby,
  output logic                  o_calibrating
);

  // ==========================================================================
  // Parameter check
  generate
    if (CONV_SLOW_P < 2 || CONV_FAST_P < 2 || XTAL_CYC_P < 1 ||
        CONV_SLOW_P >= (1 << CNT_W) || CONV_FAST_P >= (1 << CNT_W) ||
        XTAL_CYC_P >= (1 << CNT_W) || UPDATE_CYC_P < 1 ||
        UPDATE_CYC_P >= CONV_FAST_P || UPDATE_CYC_P >= CONV_SLOW_P) begin : g_bad
      $error("asr_readout_ctrl: counts out of range for the timers");
    end
  endgenerate

  // ==========================================================================
  // Declarations
  asr_state_t       state_r;
  asr_state_t       state_nxt;
  logic [3:0]       sync1_r;
  logic [3:0]       sync2_r;
  logic             pdn_s;
  logic             sclk_s;
  logic             rate_s;
  logic             xtal_s;
  logic             sclk_d_r;
  logic             sclk_rise;
  logic [CNT_W-1:0] tmr_r;
  logic [CNT_W-1:0] tmr_lim;
  logic             tmr_hit;
  logic [CNT_W-1:0] upd_r;
  logic             upd_done;
  logic             fast_r;
  logic             buf_valid;
  logic [RES_W-1:0] buf_data;
  logic             buf_ready;
  logic             conv_done;
  logic             restart;
  logic             pu_reset;
  logic             cal_r;
  logic             cal_start;
  logic [RES_W-1:0] offset_r;
  logic [RES_W:0]   diff;
  logic [RES_W-1:0] corrected;
  logic [RES_W-1:0] pending_r;
  logic [RES_W-1:0] shreg_r;
  logic [EDG_W-1:0] edge_r;
  logic             dout_r;
  logic             shift_ok;

  // ==========================================================================
  // Pin synchronisers
  // Every pin is asynchronous to the core clock; the first stage feeds
  // only the second one to keep metastability out of the logic.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {i_xtal_sel, i_rate_fast, i_sclk, i_power_down_n};
      sync2_r <= sync1_r;
    end
  end

  assign pdn_s  = sync2_r[0];
  assign sclk_s = sync2_r[1];
  assign rate_s = sync2_r[2];
  assign xtal_s = sync2_r[3];

  // Shift clock edge finder; the link clock is slow enough to sample
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d_r;

  // ==========================================================================
  // Raw conversion buffer
  // Words from the modulator wait here; when it fills, its ready stalls
  // the modulator so no word is lost while a conversion is pending.
  asr_fifo #(
    .WIDTH (RES_W),
    .DEPTH (BUF_DEPTH)
  ) u_raw_buf (
    .i_mclk     (i_mclk),
    .i_srst     (i_srst),
    .i_wr_valid (i_raw_valid),
    .i_wr_data  (i_raw_data),
    .o_wr_ready (o_raw_ready),
    .o_rd_valid (buf_valid),
    .o_rd_data  (buf_data),
    .i_rd_ready (buf_ready)
  );

  // Drain on completion; flush stale words whenever converting is off
  assign buf_ready = conv_done || (state_r == ST_OFF) ||
                     (state_r == ST_WAKE) || (state_r == ST_STANDBY);

  // ==========================================================================
  // Conversion timer
  // One timer serves the crystal wait and the conversion period; its
  // limit depends on the state and the rate latched at each restart.
  always_comb begin
    if (state_r == ST_WAKE) begin
      tmr_lim = CNT_W'(XTAL_CYC_P - 1);
    end else if (fast_r) begin
      tmr_lim = CNT_W'(CONV_FAST_P - 1);
    end else begin
      tmr_lim = CNT_W'(CONV_SLOW_P - 1);
    end
  end

  assign tmr_hit   = (tmr_r == tmr_lim);
  // A result completes once the period is over and a word is at hand
  assign conv_done = (state_r == ST_CONV) && tmr_hit && buf_valid;
  assign pu_reset  = (state_r == ST_OFF) && pdn_s;
  assign restart   = conv_done || cal_start || (state_r != ST_CONV);

  // Timer holds at its limit while waiting for the modulator
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tmr_r <= CNT_ZERO;
    end else if ((state_r == ST_WAKE) && !tmr_hit) begin
      tmr_r <= tmr_r + 1'b1;
    end else if ((state_r == ST_UPDATE) && !tmr_hit) begin
      tmr_r <= tmr_r + 1'b1;
    end else if (state_r == ST_UPDATE) begin
      tmr_r <= tmr_r;
    end else if (restart) begin
      tmr_r <= CNT_ZERO;
    end else if (!tmr_hit) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  // Rate select sampled at the start of each period
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      fast_r <= 1'b0;
    end else if (restart && (state_r != ST_UPDATE)) begin
      fast_r <= rate_s;
    end
  end

  // ==========================================================================
  // Output register update interval
  // The line stays high this long before a result; the next conversion
  // keeps running meanwhile, which is why the count must be shorter.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      upd_r <= CNT_ZERO;
    end else if (state_r != ST_UPDATE) begin
      upd_r <= CNT_ZERO;
    end else if (!upd_done) begin
      upd_r <= upd_r + 1'b1;
    end
  end

  assign upd_done = (upd_r == CNT_W'(UPDATE_CYC_P - 1));

  // ==========================================================================
  // Control state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (pdn_s) begin
          state_nxt = xtal_s ? ST_WAKE : ST_CONV;
        end
      end
      ST_WAKE: begin
        if (tmr_hit) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          state_nxt = sclk_s ? ST_STANDBY : ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        if (upd_done) begin
          state_nxt = ST_CONV;
        end
      end
      ST_STANDBY: begin
        if (!sclk_s) begin
          state_nxt = ST_CONV;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (!pdn_s) begin
      state_nxt = ST_OFF;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Offset calibration
  // The request survives standby, so a calibration asked for before
  // standby runs on the way back out.
  assign cal_start = (state_r == ST_CONV) && sclk_rise && (edge_r == EDGE_CAL);

  always_ff @(posedge i_mclk) begin
    if (i_srst || (state_r == ST_OFF)) begin
      cal_r <= 1'b0;
    end else if (cal_start) begin
      cal_r <= 1'b1;
    end else if (conv_done && !sclk_s) begin
      cal_r <= 1'b0;
    end
  end

  // Offset word; cleared by the power-up reset
  always_ff @(posedge i_mclk) begin
    if (i_srst || pu_reset) begin
      offset_r <= OFFSET_RESET;
    end else if (conv_done && !sclk_s && cal_r) begin
      offset_r <= buf_data;
    end
  end

  // ==========================================================================
  // Result correction
  // Subtract the offset one bit wider, then clip to full scale codes.
  assign diff = {buf_data[RES_W-1], buf_data} - {offset_r[RES_W-1], offset_r};

  always_comb begin
    if (diff[RES_W] && !diff[RES_W-1]) begin
      corrected = CODE_NEG_FS;
    end else if (!diff[RES_W] && diff[RES_W-1]) begin
      corrected = CODE_POS_FS;
    end else begin
      corrected = diff[RES_W-1:0];
    end
  end

  // Newest word always wins over one not yet read
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pending_r <= OFFSET_RESET;
    end else if (conv_done && !sclk_s) begin
      pending_r <= cal_r ? OFFSET_RESET : corrected;
    end
  end

  // ==========================================================================
  // Serial shifter and edge counter
  assign shift_ok = (state_r == ST_CONV) && sclk_rise && (edge_r != EDGE_STOP);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      edge_r <= EDGE_STOP;
    end else if ((state_r == ST_UPDATE) && upd_done) begin
      edge_r <= EDGE_RESET;
    end else if (state_r != ST_CONV) begin
      edge_r <= edge_r;
    end else if (shift_ok) begin
      edge_r <= edge_r + 1'b1;
    end
  end

  // Result loads with the ready indication, then moves one bit per edge
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      shreg_r <= OFFSET_RESET;
    end else if ((state_r == ST_UPDATE) && upd_done) begin
      shreg_r <= pending_r;
    end else if (shift_ok && (edge_r < EDGE_LAST)) begin
      shreg_r <= {shreg_r[RES_W-2:0], 1'b0};
    end
  end

  // ==========================================================================
  // Data/ready line
  // Bits change on the rising edge so they are steady for the host at
  // the falling edge; the sampling adds a few core cycles of delay.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      dout_r <= LINE_IDLE;
    end else if (state_r == ST_OFF || state_r == ST_WAKE) begin
      dout_r <= LINE_IDLE;
    end else if (conv_done) begin
      dout_r <= 1'b1;
    end else if ((state_r == ST_UPDATE) && upd_done) begin
      dout_r <= 1'b0;
    end else if (shift_ok && (edge_r < EDGE_LAST)) begin
      dout_r <= shreg_r[RES_W-1];
    end else if (shift_ok && (edge_r == EDGE_HIGH)) begin
      dout_r <= 1'b1;
    end
  end

  assign o_data_ready_out = dout_r;

  // ==========================================================================
  // Power controls
  // The crystal amplifier stays on in standby; only power-down or reset stops it.
  assign o_analog_en    = (state_r == ST_CONV) || (state_r == ST_UPDATE);
  assign o_osc_en       = (state_r != ST_OFF);
  assign o_standby      = (state_r == ST_STANDBY);
  assign o_calibrating  = cal_r;
  assign o_short_inputs = cal_r && o_analog_en;

endmodule
